/* File: common/sac_pkg.sv */
// Constants, types and pin map of the sampling converter control block.
// Assumes a single 250 MHz clock and synchronous pin inputs.
// Function
// - Conversion lasts 19 or 20 master edges.
// - Start near an edge costs 20 edges.
// - Mode 1 starts and holds on start rising.
// - Conversion end returns sampler to tracking.
// - Start held low: reads start conversions, except high-byte reads in byte format; busy stalls.
// - Mode 1 flag idles high, low at end.
// - First read after conversion clears the flag.
// - Flag powers up low until dummy read.
// - Format select picks word or byte/serial.
// - Word format shows all 14 bits.
// - Byte select picks low or right-justified high byte.
// - First byte read may be either byte.
// - Pins 12 to 10, below the top pin, carry strobe, clock, data.
// - Serial word is two zeros then result.
// - Data changes on serial clock rising edge.
// - Strobe falls at conversion start.
// - Serial pins open-drain, clock from master.
// - Clock continuous or released after frame.
// - Word format has no serial output.
// - Mode 2 busy low throughout conversion.
// - Result is twos complement.
`default_nettype none
package sac_pkg;
	localparam int RES_BITS = 14;
	localparam int SER_BITS = 16;
	localparam int LEAD_ZEROS = 2;
	localparam int BYTE_BITS = 8;
	localparam int HI_BITS = 6;
	localparam int BASE_EDGES = 19;
	localparam int LATE_EDGES = 20;
	localparam int FIRST_DECIDE = 2;
	localparam int EDGE_W = 5;
	localparam int WIN_W = 4;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CLK_HZ = 250_000_000;
	localparam int MCLK_HZ = 2_000_000;
	localparam int MCLK_HALF_CYC = CLK_HZ / (2 * MCLK_HZ);
	localparam int LATE_WIN_NS = 30;
	localparam int LATE_WIN_CYC = (LATE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_HBS = 13;
	localparam int PIN_STRB = 12;
	localparam int PIN_SCLK = 11;
	localparam int PIN_SDAT = 10;

	// Format select levels: high, 0 V and negative level.
	typedef enum logic [1:0] {FMT_WORD, FMT_SER_GATED, FMT_SER_CONT} sac_fmt_t;
	typedef enum logic {ST_IDLE, ST_CONV} sac_state_t;

	// Data pin bank: level driven and enable per pin.
	typedef struct packed {
		logic [RES_BITS-1:0] drv;
		logic [RES_BITS-1:0] oe;
	} sac_bus_t;
endpackage : sac_pkg
`default_nettype wire

/* File: verilog/sac_mclk_gen.sv */
// Master clock source: internal divider or external clock input.
// Assumes the external clock is synchronous and far slower than clock.
`default_nettype none
module sac_mclk_gen #(
	parameter int HALF_CYC = sac_pkg::MCLK_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic extClkSel,
	input wire logic extMclk,
	output logic mclkLevel,
	output logic mclkRise
);
	localparam int CNT_W = $clog2(HALF_CYC) + 1;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic intLvl_q;
	logic intLvl_d;
	logic extPrev_q;
	logic wrap;

	// Internal oscillator toggles every half period; the external pin is edge detected.
	always_comb
	begin
		wrap = (cnt_q == CNT_W'(HALF_CYC - 1));
		cnt_d = wrap ? '0 : cnt_q + 1'b1;
		intLvl_d = wrap ? ~intLvl_q : intLvl_q;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= '0;
			intLvl_q <= 1'b0;
			extPrev_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			intLvl_q <= intLvl_d;
			extPrev_q <= extMclk;
		end
	end

	// The rise pulse is one cycle wide, so the converter counts each edge once.
	assign mclkLevel = extClkSel ? extPrev_q : intLvl_q;
	assign mclkRise = extClkSel ? (extMclk & ~extPrev_q) : (wrap & ~intLvl_q);
endmodule : sac_mclk_gen
`default_nettype wire

/* File: verilog/sac_conv_ctrl.sv */
// Conversion control, status flag and word, byte and serial output logic.
// Assumes pins arrive synchronous to clock and the comparator answers each master edge.
`default_nettype none
module sac_conv_ctrl (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic convStartN,
	input wire logic csN,
	input wire logic rdN,
	input wire sac_pkg::sac_fmt_t fmtSel,
	input wire logic highByteSelect,
	input wire logic extClkSel,
	input wire logic extMclk,
	input wire logic compHigh,
	output logic holdMode,
	output logic busyIntN,
	output sac_pkg::sac_bus_t dataBus
);
	sac_pkg::sac_state_t state_q;
	sac_pkg::sac_state_t state_d;
	logic [sac_pkg::EDGE_W-1:0] edgeCnt_q;
	logic [sac_pkg::EDGE_W-1:0] edgeCnt_d;
	logic [sac_pkg::EDGE_W-1:0] edgeTot_q;
	logic [sac_pkg::EDGE_W-1:0] edgeTot_d;
	logic [sac_pkg::EDGE_W-1:0] nextEdge;
	logic [sac_pkg::WIN_W-1:0] winCnt_q;
	logic [sac_pkg::WIN_W-1:0] winCnt_d;
	logic [sac_pkg::RES_BITS-1:0] sar_q;
	logic [sac_pkg::RES_BITS-1:0] sar_d;
	logic [sac_pkg::RES_BITS-1:0] result_q;
	logic [sac_pkg::RES_BITS-1:0] result_d;
	logic [sac_pkg::SER_BITS-1:0] serWord;
	logic firstSeen_q;
	logic firstSeen_d;
	logic late_q;
	logic late_d;
	logic frame_q;
	logic frame_d;
	logic serBit_q;
	logic serBit_d;
	logic eoc_q;
	logic eoc_d;
	logic mode2_q;
	logic mode2_d;
	logic convPrev_q;
	logic rdPrev_q;
	sac_pkg::sac_bus_t bus_d;
	sac_pkg::sac_bus_t bus_q;
	logic mclkLevel;
	logic mclkRise;
	logic rdAct;
	logic rdFall;
	logic start;
	logic countEdge;
	logic done;
	logic readDrive;

	// Offset-binary SAR bits become twos complement by flipping the top bit.
	function automatic logic [sac_pkg::RES_BITS-1:0] toTwos(input logic [sac_pkg::RES_BITS-1:0] v);
		toTwos = {~v[sac_pkg::RES_BITS-1], v[sac_pkg::RES_BITS-2:0]};
	endfunction : toTwos

	// The serial clock follows the master clock, internal or external.
	sac_mclk_gen #(
		.HALF_CYC(sac_pkg::MCLK_HALF_CYC)
	) uMclk (
		.clock(clock),
		.rst_b(rst_b),
		.extClkSel(extClkSel),
		.extMclk(extMclk),
		.mclkLevel(mclkLevel),
		.mclkRise(mclkRise)
	);

	// Start and read detection; a second start during conversion is ignored.
	assign rdAct = ~csN & ~rdN;
	assign rdFall = rdAct & ~rdPrev_q;
	assign readDrive = rdAct & (state_q == sac_pkg::ST_IDLE);
	assign start = (state_q == sac_pkg::ST_IDLE) &
		((convStartN & ~convPrev_q) |
		(~convStartN & rdFall & ((fmtSel == sac_pkg::FMT_WORD) | ~highByteSelect)));
	// An edge within the late window after the start is only a sync edge and is not counted.
	assign countEdge = mclkRise & (firstSeen_q | (winCnt_q >= sac_pkg::WIN_W'(sac_pkg::LATE_WIN_CYC)));
	assign nextEdge = edgeCnt_q + 1'b1;
	assign done = (state_q == sac_pkg::ST_CONV) & countEdge &
		(nextEdge == sac_pkg::EDGE_W'(sac_pkg::BASE_EDGES));
	assign serWord = {{sac_pkg::LEAD_ZEROS{1'b0}}, toTwos(sar_q)};

	// Conversion sequence: SAR decisions at counted master edges 2 to 15, serial bits at counted edges 1 to 16.
	always_comb
	begin
		state_d = state_q;
		edgeCnt_d = edgeCnt_q;
		edgeTot_d = edgeTot_q;
		winCnt_d = winCnt_q;
		sar_d = sar_q;
		firstSeen_d = firstSeen_q;
		late_d = late_q;
		frame_d = frame_q;
		serBit_d = serBit_q;
		mode2_d = mode2_q;
		case (state_q)
			sac_pkg::ST_IDLE:
			begin
				if (start)
				begin
					state_d = sac_pkg::ST_CONV;
					edgeCnt_d = '0;
					edgeTot_d = '0;
					winCnt_d = '0;
					sar_d = '0;
					firstSeen_d = 1'b0;
					late_d = 1'b0;
					frame_d = 1'b1;
					serBit_d = 1'b0;
					mode2_d = ~convStartN;
				end
			end
			sac_pkg::ST_CONV:
			begin
				if (winCnt_q != sac_pkg::WIN_W'(sac_pkg::LATE_WIN_CYC))
					winCnt_d = winCnt_q + 1'b1;
				if (mclkRise)
				begin
					edgeTot_d = edgeTot_q + 1'b1;
					firstSeen_d = 1'b1;
					if (!firstSeen_q)
						late_d = ~countEdge;
				end
				if (countEdge)
				begin
					edgeCnt_d = nextEdge;
					if (nextEdge >= sac_pkg::EDGE_W'(sac_pkg::FIRST_DECIDE) &&
						nextEdge < sac_pkg::EDGE_W'(sac_pkg::FIRST_DECIDE + sac_pkg::RES_BITS))
						sar_d[4'(sac_pkg::RES_BITS + sac_pkg::FIRST_DECIDE - 1 - int'(nextEdge))] = compHigh;
					if (nextEdge <= sac_pkg::EDGE_W'(sac_pkg::SER_BITS))
						serBit_d = serWord[4'(sac_pkg::SER_BITS - int'(nextEdge))];
					else
						frame_d = 1'b0;
					if (done)
						state_d = sac_pkg::ST_IDLE;
				end
			end
			default:
				state_d = sac_pkg::ST_IDLE;
		endcase
	end

	// Result latch and the mode 1 end flag; a completing conversion beats a clearing read.
	always_comb
	begin
		result_d = done ? toTwos(sar_q) : result_q;
		eoc_d = (done & ~mode2_q) | (eoc_q & ~(rdFall & (state_q == sac_pkg::ST_IDLE)));
	end

	// Pin bank: word read, byte read, and open-drain serial lines pulled low when enabled.
	always_comb
	begin
		bus_d.drv = '0;
		bus_d.oe = '0;
		if (fmtSel == sac_pkg::FMT_WORD)
		begin
			if (readDrive)
			begin
				bus_d.drv = result_q;
				bus_d.oe = '1;
			end
		end
		else
		begin
			if (readDrive)
			begin
				bus_d.oe[sac_pkg::BYTE_BITS-1:0] = '1;
				bus_d.drv[sac_pkg::BYTE_BITS-1:0] = highByteSelect ?
					{{(sac_pkg::BYTE_BITS - sac_pkg::HI_BITS){1'b0}},
					result_q[sac_pkg::RES_BITS-1 -: sac_pkg::HI_BITS]} :
					result_q[sac_pkg::BYTE_BITS-1:0];
			end
			bus_d.oe[sac_pkg::PIN_STRB] = frame_q;
			bus_d.oe[sac_pkg::PIN_SCLK] = (frame_q | (fmtSel == sac_pkg::FMT_SER_CONT)) & ~mclkLevel;
			bus_d.oe[sac_pkg::PIN_SDAT] = frame_q & ~serBit_q;
		end
	end

	// All control state registers; the flag resets set, as after a power-up conversion.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= sac_pkg::ST_IDLE;
			edgeCnt_q <= '0;
			edgeTot_q <= '0;
			winCnt_q <= '0;
			sar_q <= '0;
			result_q <= '0;
			firstSeen_q <= 1'b0;
			late_q <= 1'b0;
			frame_q <= 1'b0;
			serBit_q <= 1'b1;
			eoc_q <= 1'b1;
			mode2_q <= 1'b0;
			convPrev_q <= 1'b1;
			rdPrev_q <= 1'b0;
			bus_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			edgeCnt_q <= edgeCnt_d;
			edgeTot_q <= edgeTot_d;
			winCnt_q <= winCnt_d;
			sar_q <= sar_d;
			result_q <= result_d;
			firstSeen_q <= firstSeen_d;
			late_q <= late_d;
			frame_q <= frame_d;
			serBit_q <= serBit_d;
			eoc_q <= eoc_d;
			mode2_q <= mode2_d;
			convPrev_q <= convStartN;
			rdPrev_q <= rdAct;
			bus_q <= bus_d;
		end
	end

	// holdMode and dataBus come straight from flops; busyIntN is a mux of flops selected by mode2_q.
	assign holdMode = (state_q == sac_pkg::ST_CONV);
	assign busyIntN = mode2_q ? (state_q == sac_pkg::ST_IDLE) : ~eoc_q;
	assign dataBus = bus_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_HOLD_ON_START: assert property (start |=> holdMode)
		else $error("Sampler not held after start.");
	AST_CONV_EDGES: assert property (done |-> (edgeTot_q == sac_pkg::EDGE_W'(sac_pkg::BASE_EDGES - 1) ||
		edgeTot_q == sac_pkg::EDGE_W'(sac_pkg::LATE_EDGES - 1)))
		else $error("Conversion edge count outside 19 to 20.");
	AST_LATE_TWENTY: assert property (done && late_q |-> edgeTot_q == sac_pkg::EDGE_W'(sac_pkg::LATE_EDGES - 1))
		else $error("Late start did not take 20 edges.");
	AST_TRACK_AFTER: assert property (done |=> !holdMode)
		else $error("Sampler not tracking after conversion.");
	AST_FLAG_LOW: assert property (done && !mode2_q |=> !busyIntN)
		else $error("End flag not low after mode 1 conversion.");
	AST_FLAG_CLEAR: assert property (eoc_q && rdFall && !holdMode |=> !eoc_q)
		else $error("Read did not clear end flag.");
	AST_BUSY_M2: assert property (mode2_q && holdMode |-> !busyIntN)
		else $error("Busy not low during mode 2 conversion.");
	AST_WORD_READ: assert property (readDrive && fmtSel == sac_pkg::FMT_WORD
		|=> dataBus.oe == '1 && dataBus.drv == $past(result_q))
		else $error("Word read shows wrong data.");
	AST_HIGH_BYTE: assert property (readDrive && fmtSel != sac_pkg::FMT_WORD && highByteSelect
		|=> dataBus.drv[7:0] == {2'b00, $past(result_q[13:8])})
		else $error("High byte not right justified.");
	AST_NO_SERIAL: assert property (fmtSel == sac_pkg::FMT_WORD && !rdAct |=> dataBus.oe == '0)
		else $error("Pins driven in word format without read.");
	AST_STROBE_START: assert property (start && fmtSel != sac_pkg::FMT_WORD |=> ##1 dataBus.oe[12])
		else $error("Frame strobe not low after start.");

	COV_MODE1: cover property (start && convStartN ##[1:1000] done);
	COV_MODE2: cover property (start && !convStartN ##[1:1000] done);
	COV_LATE: cover property (done && late_q);
	COV_HIGH_READ: cover property (readDrive && highByteSelect && fmtSel != sac_pkg::FMT_WORD);
endmodule : sac_conv_ctrl
`default_nettype wire

/* File: tb/sac_far_model.sv */
// Far-side model: external master clock source and a comparator answering one fixed code.
// Assumes the block decides bit 13 down to 0 at counted master rising edges 2 to 15.
`default_nettype none
module sac_far_model #(
	parameter int HALF = 12
) (
	input wire logic clock,
	input wire logic holdMode,
	input wire logic [13:0] code,
	output logic extMclk,
	output logic compHigh,
	output logic [4:0] edgeCnt
);
	timeunit 1ns;
	timeprecision 100ps;
	int phase;
	logic holdPrev;
	initial
	begin
		{extMclk, compHigh, edgeCnt, holdPrev} = '0;
		phase = 0;
	end
	// Decisions change at the falling master edge so they are stable around the rising one.
	always @(negedge clock)
	begin
		holdPrev <= holdMode;
		if (holdMode && !holdPrev)
			edgeCnt <= 5'h0;
		if (phase == HALF - 1)
		begin
			phase <= 0;
			extMclk <= ~extMclk;
			if (!extMclk && holdMode)
				edgeCnt <= edgeCnt + 5'h1;
			if (extMclk)
				compHigh <= (edgeCnt >= 5'h1 && edgeCnt <= 5'he) ? code[5'he - edgeCnt] : 1'b0;
		end
		else
			phase <= phase + 1;
	end
endmodule : sac_far_model
`default_nettype wire

/* File: tb/sac_conv_ctrl_bench.sv */
// Self-checking bench of the converter control block.
// Assumes the far-side model supplies the master clock with a 24 cycle period.
`default_nettype none
module sac_conv_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [13:0] CODE = 14'h2c35;
	localparam logic [13:0] EXP = CODE ^ 14'h2000;
	logic clock = 1'b0;
	logic rst_b, convStartN, csN, rdN, highByteSelect, extClkSel, extMclk, compHigh, holdMode, busyIntN;
	logic anySer, busySeen;
	logic [4:0] edgeCnt;
	logic [13:0] rd, rdOe;
	logic [15:0] serBits;
	int numErrors, checked, nBits, ch, tg;
	sac_pkg::sac_fmt_t fmtSel;
	sac_pkg::sac_bus_t dataBus;
	always #2 clock = ~clock;
	sac_conv_ctrl dut (.clock(clock), .rst_b(rst_b), .convStartN(convStartN), .csN(csN), .rdN(rdN),
		.fmtSel(fmtSel), .highByteSelect(highByteSelect), .extClkSel(extClkSel), .extMclk(extMclk),
		.compHigh(compHigh), .holdMode(holdMode), .busyIntN(busyIntN), .dataBus(dataBus));
	sac_far_model far (.clock(clock), .holdMode(holdMode), .code(CODE), .extMclk(extMclk),
		.compHigh(compHigh), .edgeCnt(edgeCnt));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			numErrors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic stopTest;
		$display("checks %0d errors %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stopTest
	// Start pulse falls k cycles after a master rise and rises one cycle later; small k keeps the first edge counted.
	task automatic startConv(input int k);
		@(posedge extMclk);
		repeat (k) @(negedge clock);
		convStartN = 1'b0;
		@(negedge clock);
		convStartN = 1'b1;
		repeat (2) @(negedge clock);
	endtask : startConv
	// Start stays high while reading, and reads only happen when idle.
	task automatic doRead(input logic hbs);
		@(negedge clock);
		{csN, rdN, highByteSelect} = {2'b00, hbs};
		repeat (2) @(negedge clock);
		{rd, rdOe} = {dataBus.drv, dataBus.oe};
		{csN, rdN} = 2'b11;
		@(negedge clock);
	endtask : doRead
	// Waits for the end of conversion and captures the open-drain serial frame on the way.
	task automatic waitConv;
		logic prevClk;
		{serBits, nBits, anySer, busySeen} = '0;
		prevClk = dataBus.oe[11];
		for (int i = 0; i < 1000 && holdMode !== 1'b0; i++)
		begin
			@(negedge clock);
			anySer |= |dataBus.oe[12:10];
			busySeen |= busyIntN & holdMode;
			if (dataBus.oe[11] && !prevClk && dataBus.oe[12])
			begin
				serBits = {serBits[14:0], ~dataBus.oe[10]};
				nBits++;
			end
			prevClk = dataBus.oe[11];
		end
		chk(holdMode, 0, "end of conversion");
		@(negedge clock);
	endtask : waitConv
	// Counts cycles with the serial clock pulled low and how often it changes level.
	task automatic sclkActivity;
		logic prev;
		ch = 0;
		tg = 0;
		prev = dataBus.oe[11];
		repeat (60)
		begin
			@(negedge clock);
			ch += int'(dataBus.oe[11]);
			tg += int'(dataBus.oe[11] !== prev);
			prev = dataBus.oe[11];
		end
	endtask : sclkActivity
	task automatic tWord;
		startConv(13);
		chk(holdMode, 1, "hold");
		chk(busyIntN, 1, "flag idle");
		waitConv;
		chk(edgeCnt, 19, "edges");
		chk(busyIntN, 0, "flag end");
		chk(anySer, 0, "serial in word");
		doRead(1'b0);
		chk(rd, EXP, "word");
		chk(rdOe, 14'h3fff, "word oe");
		chk(busyIntN, 1, "flag clear");
		startConv(19);
		waitConv;
		chk(edgeCnt, 20, "late edges");
		doRead(1'b0);
	endtask : tWord
	task automatic tSerial;
		fmtSel = sac_pkg::FMT_SER_GATED;
		startConv(13);
		waitConv;
		chk(nBits, 16, "bit count");
		chk(serBits, {2'b00, EXP}, "serial word");
		sclkActivity;
		chk(ch, 0, "gated clock");
		doRead(1'b1);
		chk({rdOe[13], rd[7:0]}, {1'b0, 2'b00, EXP[13:8]}, "high byte");
		chk(busyIntN, 1, "first byte clears");
		doRead(1'b0);
		chk({rdOe[7:0], rd[7:0]}, {8'hff, EXP[7:0]}, "low byte");
		fmtSel = sac_pkg::FMT_SER_CONT;
		sclkActivity;
		chk(16'(tg >= 4 && ch > 0), 1, "free clock");
	endtask : tSerial
	task automatic tMode2;
		fmtSel = sac_pkg::FMT_WORD;
		convStartN = 1'b0;
		@(posedge extMclk);
		repeat (13) @(negedge clock);
		{csN, rdN} = 2'b00;
		repeat (2) @(negedge clock);
		chk(holdMode, 1, "mode 2 hold");
		waitConv;
		chk(busySeen, 0, "busy held low");
		chk(busyIntN, 1, "busy released");
		@(negedge clock);
		chk(dataBus.drv, EXP, "mode 2 data");
		{csN, rdN} = 2'b11;
		@(negedge clock);
		// A byte format read with the high byte selected must not start a conversion.
		fmtSel = sac_pkg::FMT_SER_GATED;
		{csN, rdN, highByteSelect} = 3'b001;
		repeat (2) @(negedge clock);
		chk(holdMode, 0, "mode 2 high byte start");
		{csN, rdN} = 2'b11;
	endtask : tMode2
	// Internal master clock: the hold span must lie between 18 and 20 internal master periods.
	task automatic tIntClk;
		int n;
		fmtSel = sac_pkg::FMT_WORD;
		extClkSel = 1'b0;
		n = 0;
		startConv(13);
		for (int i = 0; i < 3000 && holdMode === 1'b1; i++)
		begin
			@(negedge clock);
			n++;
		end
		chk(16'(n >= (sac_pkg::BASE_EDGES - 1) * 2 * sac_pkg::MCLK_HALF_CYC &&
			n <= sac_pkg::LATE_EDGES * 2 * sac_pkg::MCLK_HALF_CYC), 1, "internal clock span");
		chk(busyIntN, 0, "internal clock flag");
		doRead(1'b0);
		chk(busyIntN, 1, "internal clock clear");
		extClkSel = 1'b1;
	endtask : tIntClk
	initial
	begin
		{convStartN, csN, rdN, highByteSelect, rst_b} = 5'b11100;
		extClkSel = 1'b1;
		fmtSel = sac_pkg::FMT_WORD;
		repeat (4) @(negedge clock);
		rst_b = 1'b1;
		repeat (2) @(negedge clock);
		chk(holdMode, 0, "reset hold");
		chk(busyIntN, 0, "power-up flag");
		doRead(1'b0);
		chk(busyIntN, 1, "dummy read");
		tWord;
		tSerial;
		tIntClk;
		tMode2;
		stopTest;
	end
	// A hang is cut short after several times the expected run.
	initial
	begin
		#100000;
		numErrors++;
		stopTest;
	end
endmodule : sac_conv_ctrl_bench
`default_nettype wire
